// ==== scs_servo_cycle_sequencer.v ====
`timescale 1ns/1ps
`include "scs_defines.vh"
module scs_servo_cycle_sequencer #(
  parameter POLL_CLKS = `SCS_POLL_CLKS,
  parameter ERR_W     = 16,
  parameter TQ_W      = 16,
  parameter TMR_W     = 16,
  parameter DATA_W    = `SCS_DATA_W,
  parameter STAT_W    = 16
) (
  ref_clk,
  rst_n,
  clk_en,
  concurrency_on_cmd,
  concurrency_off_cmd,
  hold_entry_mode,
  hold_enter_thresh,
  hold_exit_thresh,
  hold_check_torque,
  hold_settle_delay,
  error_limit_delay,
  tq_move_limit,
  tq_hold_limit,
  pos_error,
  closed_loop_torque,
  control_output_calc,
  traj_active,
  stop_cond,
  prog_cmd_valid,
  prog_cmd_is_motion,
  prog_cmd_long,
  prog_cmd_done,
  host_motion_cmd,
  ser_rx_valid,
  ser_rx_data,
  ser_tx_valid,
  ser_tx_data,
  ser_rx_take,
  ser_tx_take,
  stat_word0_in,
  stat_word1_in,
  stat_word2_in,
  io_in,
  io_out_next,
  err_user_in,
  err_fixed_in,
  task_strobe,
  servo_cycle_tick,
  serial_poll_tick,
  prog_cmd_issue,
  motion_start,
  concurrency_en,
  open_loop,
  error_limit_timer,
  torque_cmd,
  control_output,
  stat_word0,
  stat_word1,
  stat_word2,
  io_in_sampled,
  io_out,
  err_flag
);
  input                   ref_clk;
  input                   rst_n;
  input                   clk_en;
  input                   concurrency_on_cmd;
  input                   concurrency_off_cmd;
  input                   hold_entry_mode;
  input  [ERR_W-1:0]      hold_enter_thresh;
  input  [ERR_W-1:0]      hold_exit_thresh;
  input                   hold_check_torque;
  input  [TMR_W-1:0]      hold_settle_delay;
  input  [TMR_W-1:0]      error_limit_delay;
  input  [TQ_W-1:0]       tq_move_limit;
  input  [TQ_W-1:0]       tq_hold_limit;
  input  [ERR_W-1:0]      pos_error;
  input  [TQ_W-1:0]       closed_loop_torque;
  input  [TQ_W-1:0]       control_output_calc;
  input                   traj_active;
  input                   stop_cond;
  input                   prog_cmd_valid;
  input                   prog_cmd_is_motion;
  input                   prog_cmd_long;
  input                   prog_cmd_done;
  input                   host_motion_cmd;
  input                   ser_rx_valid;
  input  [DATA_W-1:0]     ser_rx_data;
  input                   ser_tx_valid;
  input  [DATA_W-1:0]     ser_tx_data;
  output                  ser_rx_take;
  output                  ser_tx_take;
  input  [STAT_W-1:0]     stat_word0_in;
  input  [STAT_W-1:0]     stat_word1_in;
  input  [STAT_W-1:0]     stat_word2_in;
  input  [7:0]            io_in;
  input  [7:0]            io_out_next;
  input                   err_user_in;
  input                   err_fixed_in;
  output [`SCS_NUM_TASKS-1:0] task_strobe;
  output                  servo_cycle_tick;
  output                  serial_poll_tick;
  output                  prog_cmd_issue;
  output                  motion_start;
  output                  concurrency_en;
  output                  open_loop;
  output                  error_limit_timer;
  output [TQ_W-1:0]       torque_cmd;
  output [TQ_W-1:0]       control_output;
  output [STAT_W-1:0]     stat_word0;
  output [STAT_W-1:0]     stat_word1;
  output [STAT_W-1:0]     stat_word2;
  output [7:0]            io_in_sampled;
  output [7:0]            io_out;
  output                  err_flag;

  // Task sequencer states, one-hot
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_CTRL = 7'h02;
  localparam [6:0] ST_PROG = 7'h04;
  localparam [6:0] ST_MOT  = 7'h08;
  localparam [6:0] ST_STAT = 7'h10;
  localparam [6:0] ST_ERR  = 7'h20;
  localparam [6:0] ST_DONE = 7'h40;

  wire                    poll_tick;
  wire                    cycle_tick;
  reg  [6:0]              st_r;
  reg  [6:0]              st_nxt;
  reg                     conc_r;
  reg                     prog_busy_r;
  reg                     motion_wait_r;
  reg                     issue_r;
  reg                     mstart_r;
  reg                     open_r;
  reg  [TMR_W-1:0]        settle_cnt_r;
  reg                     settle_run_r;
  reg  [TMR_W-1:0]        erl_cnt_r;
  reg                     erl_done_r;
  reg  [TQ_W-1:0]         torque_r;
  reg  [TQ_W-1:0]         ctrl_r;
  reg  [STAT_W-1:0]       sw0_r;
  reg  [STAT_W-1:0]       sw1_r;
  reg  [STAT_W-1:0]       sw2_r;
  reg  [7:0]              io_in_s1_r;
  reg  [7:0]              io_in_s2_r;
  reg  [7:0]              io_in_r;
  reg  [7:0]              io_out_r;
  reg                     err_r;
  wire                    hold_en;
  wire                    enter_ok;
  wire                    torque_ok;
  wire                    exit_now;
  wire [TQ_W-1:0]         tq_limit;
  wire                    can_issue;

  scs_tick_gen #(
    .POLL_CLKS (POLL_CLKS)
  ) u_tick (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .poll_tick  (poll_tick),
    .cycle_tick (cycle_tick),
    .poll_idx   ()
  );

  assign servo_cycle_tick = cycle_tick;
  assign serial_poll_tick = poll_tick;
  // One byte each way per poll period
  assign ser_rx_take = poll_tick & ser_rx_valid;
  assign ser_tx_take = poll_tick & ser_tx_valid;

  // One-hot task strobes; serial strobes thrice per cycle
  assign task_strobe[`SCS_TASK_SERIAL]  = poll_tick;
  assign task_strobe[`SCS_TASK_CONTROL] = st_r[1] & clk_en;
  assign task_strobe[`SCS_TASK_PROGRAM] = st_r[2] & clk_en;
  assign task_strobe[`SCS_TASK_MOTION]  = st_r[3] & clk_en;
  assign task_strobe[`SCS_TASK_STATUS]  = st_r[4] & clk_en;
  assign task_strobe[`SCS_TASK_ERROR]   = st_r[5] & clk_en;

  // Task walk starts on the cycle tick, third serial slot done first
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (cycle_tick) st_nxt = ST_CTRL;
      ST_CTRL: st_nxt = ST_PROG;
      ST_PROG: st_nxt = ST_MOT;
      ST_MOT:  st_nxt = ST_STAT;
      ST_STAT: st_nxt = ST_ERR;
      ST_ERR:  st_nxt = ST_DONE;
      ST_DONE: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_IDLE;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Off wins over on if both arrive together, safer default
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conc_r <= `SCS_CONC_RST;
    end else if (clk_en) begin
      if (concurrency_off_cmd) begin
        conc_r <= 1'b0;
      end else if (concurrency_on_cmd) begin
        conc_r <= 1'b1;
      end
    end
  end
  assign concurrency_en = conc_r;

  // Program issue gate: previous done, and generator idle unless concurrent
  assign can_issue = prog_cmd_valid & ~prog_busy_r & ~motion_wait_r
                   & (conc_r | ~traj_active);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_busy_r   <= 1'b0;
      motion_wait_r <= 1'b0;
      issue_r       <= 1'b0;
      mstart_r      <= 1'b0;
    end else if (clk_en) begin
      issue_r  <= 1'b0;
      mstart_r <= 1'b0;
      // Delay and wait commands hold until done; others finish in the slot
      if (prog_busy_r & prog_cmd_done) begin
        prog_busy_r <= 1'b0;
      end
      // Halted program resumes once generator idle or stop seen
      if (motion_wait_r & (~traj_active | stop_cond)) begin
        motion_wait_r <= 1'b0;
      end
      if (st_r[2] & can_issue) begin
        issue_r     <= 1'b1;
        prog_busy_r <= prog_cmd_long;
        // Without concurrency the motion halts program flow
        if (prog_cmd_is_motion & ~conc_r) begin
          motion_wait_r <= 1'b1;
        end
      end
      if (st_r[3] & ((issue_r & prog_cmd_is_motion) | host_motion_cmd)) begin
        mstart_r <= 1'b1;
      end
    end
  end
  assign prog_cmd_issue = issue_r;
  assign motion_start   = mstart_r;

  // Deadband hold decisions
  assign hold_en   = (hold_enter_thresh != {ERR_W{1'b0}})
                   | (hold_exit_thresh != {ERR_W{1'b0}});
  assign tq_limit  = erl_done_r ? tq_hold_limit : tq_move_limit;
  assign torque_ok = ~hold_check_torque | (closed_loop_torque <= tq_limit);
  assign enter_ok  = hold_en & (pos_error <= hold_enter_thresh)
                   & torque_ok
                   & (hold_entry_mode | ~traj_active);
  assign exit_now  = pos_error >= hold_exit_thresh;

  // Evaluated once per cycle in the control slot, exit is immediate
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_r       <= 1'b0;
      settle_cnt_r <= {TMR_W{1'b0}};
      settle_run_r <= 1'b0;
      erl_cnt_r    <= {TMR_W{1'b0}};
      erl_done_r   <= 1'b0;
      ctrl_r       <= {TQ_W{1'b0}};
      torque_r     <= {TQ_W{1'b0}};
    end else if (clk_en) begin
      if (open_r & (exit_now | ~hold_en)) begin
        open_r       <= 1'b0;
        settle_run_r <= 1'b0;
      end else if (st_r[1]) begin
        if (open_r) begin
          // Error-limit timer counts servo cycles after entry
          if (erl_cnt_r >= error_limit_delay) begin
            erl_done_r <= 1'b1;
          end else begin
            erl_cnt_r <= erl_cnt_r + {{(TMR_W-1){1'b0}}, 1'b1};
          end
          torque_r <= erl_done_r ? tq_hold_limit : tq_move_limit;
        end else begin
          ctrl_r   <= control_output_calc;
          torque_r <= control_output_calc;
          if (~enter_ok) begin
            settle_run_r <= 1'b0;
            settle_cnt_r <= {TMR_W{1'b0}};
          end else if (settle_cnt_r >= hold_settle_delay) begin
            open_r       <= 1'b1;
            settle_run_r <= 1'b0;
            settle_cnt_r <= {TMR_W{1'b0}};
            erl_cnt_r    <= {TMR_W{1'b0}};
            erl_done_r   <= 1'b0;
            torque_r     <= tq_move_limit;
          end else begin
            settle_run_r <= 1'b1;
            settle_cnt_r <= settle_cnt_r + {{(TMR_W-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end
  assign open_loop         = open_r;
  assign error_limit_timer = open_r & ~erl_done_r;
  assign torque_cmd        = torque_r;
  assign control_output    = ctrl_r;

  // Pin inputs pass two flops before use
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_in_s1_r <= 8'h00;
      io_in_s2_r <= 8'h00;
    end else if (clk_en) begin
      io_in_s1_r <= io_in;
      io_in_s2_r <= io_in_s1_r;
    end
  end

  // Status words and I/O refreshed only in their slot
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw0_r    <= {STAT_W{1'b0}};
      sw1_r    <= {STAT_W{1'b0}};
      sw2_r    <= {STAT_W{1'b0}};
      io_in_r  <= 8'h00;
      io_out_r <= 8'h00;
      err_r    <= 1'b0;
    end else if (clk_en) begin
      if (st_r[4]) begin
        sw0_r    <= stat_word0_in;
        sw1_r    <= stat_word1_in;
        sw2_r    <= stat_word2_in;
        io_in_r  <= io_in_s2_r;
        io_out_r <= io_out_next;
      end
      if (st_r[5]) begin
        err_r <= err_user_in | err_fixed_in;
      end
    end
  end
  assign stat_word0    = sw0_r;
  assign stat_word1    = sw1_r;
  assign stat_word2    = sw2_r;
  assign io_in_sampled = io_in_r;
  assign io_out        = io_out_r;
  assign err_flag      = err_r;
endmodule // scs_servo_cycle_sequencer

// ==== scs_defines.vh ====
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH
// Clock rate and timing
`define SCS_CLK_MHZ          100
`define SCS_SERVO_CYCLE_US   120
`define SCS_POLL_US          40
`define SCS_CYCLE_CLKS       (`SCS_SERVO_CYCLE_US * `SCS_CLK_MHZ)
`define SCS_POLL_CLKS        (`SCS_POLL_US * `SCS_CLK_MHZ)
`define SCS_POLLS_PER_CYCLE  3
// Task slot positions (bit index of one-hot task strobe)
`define SCS_TASK_SERIAL      0
`define SCS_TASK_CONTROL     1
`define SCS_TASK_PROGRAM     2
`define SCS_TASK_MOTION      3
`define SCS_TASK_STATUS      4
`define SCS_TASK_ERROR       5
`define SCS_NUM_TASKS        6
// Reset values and serial data width
`define SCS_CONC_RST         1'b0
`define SCS_DATA_W           8
`endif

// ==== scs_tick_gen.v ====
`timescale 1ns/1ps
`include "scs_defines.vh"
module scs_tick_gen #(
  parameter POLL_CLKS = `SCS_POLL_CLKS,
  parameter CNT_W     = 16
) (
  ref_clk,
  rst_n,
  clk_en,
  poll_tick,
  cycle_tick,
  poll_idx
);
  input              ref_clk;
  input              rst_n;
  input              clk_en;
  output             poll_tick;
  output             cycle_tick;
  output [1:0]       poll_idx;
  reg    [CNT_W-1:0] cnt_r;
  reg    [1:0]       poll_idx_r;
  wire               poll_end;
  // Full-width terms first, then cut on purpose to the counter widths
  localparam [31:0]      POLL_LAST_W = POLL_CLKS - 1;
  localparam [31:0]      IDX_LAST_W  = `SCS_POLLS_PER_CYCLE - 1;
  localparam [CNT_W-1:0] POLL_LAST   = POLL_LAST_W[CNT_W-1:0];
  localparam [1:0]       IDX_LAST    = IDX_LAST_W[1:0];
  assign poll_end   = (cnt_r == POLL_LAST);
  assign poll_tick  = clk_en & poll_end;
  assign cycle_tick = poll_tick & (poll_idx_r == IDX_LAST);
  assign poll_idx   = poll_idx_r;
  // One free counter, cycle is three poll periods
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r      <= {CNT_W{1'b0}};
      poll_idx_r <= 2'h0;
    end else if (clk_en) begin
      if (poll_end) begin
        cnt_r <= {CNT_W{1'b0}};
        if (poll_idx_r == IDX_LAST) begin
          poll_idx_r <= 2'h0;
        end else begin
          poll_idx_r <= poll_idx_r + 2'h1;
        end
      end else begin
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // scs_tick_gen

// ==== scs_seq_props.sv ====
`timescale 1ns/1ps
`include "scs_defines.vh"
module scs_seq_props #(
  parameter ERR_W  = 16,
  parameter STAT_W = 16
) (
  input wire logic                      ref_clk,
  input wire logic                      rst_n,
  input wire logic                      clk_en,
  input wire logic                      concurrency_off_cmd,
  input wire logic                      concurrency_en,
  input wire logic                      traj_active,
  input wire logic                      hold_entry_mode,
  input wire logic [ERR_W-1:0]          pos_error,
  input wire logic [ERR_W-1:0]          hold_enter_thresh,
  input wire logic [ERR_W-1:0]          hold_exit_thresh,
  input wire logic                      ser_rx_valid,
  input wire logic                      ser_rx_take,
  input wire logic [`SCS_NUM_TASKS-1:0] task_strobe,
  input wire logic                      servo_cycle_tick,
  input wire logic                      serial_poll_tick,
  input wire logic                      prog_cmd_issue,
  input wire logic                      motion_start,
  input wire logic                      open_loop,
  input wire logic [STAT_W-1:0]         stat_word0,
  input wire logic                      err_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Slot chain after each cycle tick; assumes clock enable held high
  property p_order;
    servo_cycle_tick && clk_en |=> task_strobe[1] ##1 task_strobe[2] ##1 task_strobe[3]
      ##1 task_strobe[4] ##1 task_strobe[5];
  endproperty
  a_order: assert property (p_order) else $error("slot order broken");
  property p_take;
    ser_rx_take |-> serial_poll_tick && ser_rx_valid && task_strobe[0];
  endproperty
  a_take: assert property (p_take) else $error("byte taken off poll");
  property p_issue;
    prog_cmd_issue |-> $past(task_strobe[2]);
  endproperty
  a_issue: assert property (p_issue) else $error("issue outside slot");
  property p_block;
    task_strobe[2] && !concurrency_en && traj_active |=> !prog_cmd_issue;
  endproperty
  a_block: assert property (p_block) else $error("issue while moving");
  property p_motion;
    motion_start |-> $past(task_strobe[3]);
  endproperty
  a_motion: assert property (p_motion) else $error("motion outside slot");
  property p_exit;
    open_loop && pos_error >= hold_exit_thresh |=> !open_loop;
  endproperty
  a_exit: assert property (p_exit) else $error("open loop kept");
  property p_zero;
    hold_enter_thresh == 0 && hold_exit_thresh == 0 |=> !open_loop;
  endproperty
  a_zero: assert property (p_zero) else $error("hold not disabled");
  property p_mode;
    $rose(open_loop) |-> $past(hold_entry_mode) || !$past(traj_active);
  endproperty
  a_mode: assert property (p_mode) else $error("entry while moving");
  property p_conc_off;
    concurrency_off_cmd && clk_en |=> !concurrency_en;
  endproperty
  a_conc_off: assert property (p_conc_off) else $error("off ignored");
  property p_stat;
    $changed(stat_word0) |-> $past(task_strobe[4]);
  endproperty
  a_stat: assert property (p_stat) else $error("status off slot");
  property p_err;
    $changed(err_flag) |-> $past(task_strobe[5]);
  endproperty
  a_err: assert property (p_err) else $error("error off slot");
endmodule // scs_seq_props

bind scs_servo_cycle_sequencer scs_seq_props #(.ERR_W(ERR_W), .STAT_W(STAT_W)) i_scs_seq_props (.*);

// ==== scs_host_model.sv ====
`timescale 1ns/1ps
module scs_host_model (
  input  wire logic       ref_clk,
  input  wire logic       send,
  input  wire logic       take,
  output logic            valid,
  output logic [7:0]      data,
  output int              n_sent
);
  logic [7:0] byte_r;
  // Start idle with a known byte queued
  initial begin
    byte_r = 8'hA5;
    n_sent = 0;
    valid = 1'b0;
    data = 8'h5A;
  end
  // One byte per take; the next waits for the next poll
  always @(posedge ref_clk) begin
    if (take === 1'b1 && valid) begin
      n_sent <= n_sent + 1;
      byte_r <= byte_r + 8'h01;
    end
  end
  // Idle line shows the inverse so stale data never looks valid
  always @(negedge ref_clk) begin
    valid <= send;
    data  <= send ? byte_r : ~byte_r;
  end
endmodule // scs_host_model

// ==== scs_servo_cycle_sequencer_tb.sv ====
`timescale 1ns/1ps
`include "scs_defines.vh"
module scs_servo_cycle_sequencer_tb;
  localparam PC = 10;
  logic ref_clk, rst_n, clk_en, concurrency_on_cmd, concurrency_off_cmd, hold_entry_mode;
  logic hold_check_torque, traj_active, stop_cond, prog_cmd_valid, prog_cmd_is_motion;
  logic prog_cmd_long, prog_cmd_done, host_motion_cmd, err_user_in, err_fixed_in, send;
  logic [15:0] hold_enter_thresh, hold_exit_thresh, hold_settle_delay, error_limit_delay;
  logic [15:0] tq_move_limit, tq_hold_limit, pos_error, closed_loop_torque, control_output_calc;
  logic [15:0] stat_word0_in, stat_word1_in, stat_word2_in, stat_word0, stat_word1, stat_word2;
  logic [15:0] torque_cmd, control_output;
  logic [7:0] ser_rx_data, ser_tx_data, io_in, io_out_next, io_in_sampled, io_out;
  logic [5:0] task_strobe;
  logic ser_rx_valid, ser_tx_valid, ser_rx_take, ser_tx_take, servo_cycle_tick, serial_poll_tick;
  logic prog_cmd_issue, motion_start, concurrency_en, open_loop, error_limit_timer, err_flag;
  int n_mismatch, checks_done, n_rx, n_tx, n_iss, n_mot, n_open, n0, k;

  scs_servo_cycle_sequencer #(.POLL_CLKS(PC)) i_scs_servo_cycle_sequencer (.*);
  scs_host_model i_scs_host_model_rx (.ref_clk(ref_clk), .send(send), .take(ser_rx_take),
    .valid(ser_rx_valid), .data(ser_rx_data), .n_sent(n_rx));
  scs_host_model i_scs_host_model_tx (.ref_clk(ref_clk), .send(send), .take(ser_tx_take),
    .valid(ser_tx_valid), .data(ser_tx_data), .n_sent(n_tx));

  // Free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Pulse counters, sampled mid-cycle
  always @(negedge ref_clk) begin
    if (prog_cmd_issue === 1'b1) n_iss++;
    if (motion_start === 1'b1) n_mot++;
    if (open_loop === 1'b1) n_open++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Returns in the control-slot cycle, so new inputs meet that slot
  task automatic cyc(input int n);
    repeat (n) begin
      k = 0;
      do begin @(negedge ref_clk); k++; end while (servo_cycle_tick !== 1'b1 && k < 40);
      @(negedge ref_clk);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Cycle length and serial bytes per cycle
  task automatic t_serial;
    send = 1'b1;
    cyc(1);
    k = 0;
    do begin @(negedge ref_clk); k++; end while (servo_cycle_tick !== 1'b1 && k < 100);
    chk(k, 3 * PC - 1);
    // Step past the tick edge so its poll is not counted twice
    @(negedge ref_clk);
    n0 = n_rx;
    cyc(4);
    chk(n_rx - n0, 12);
    chk(n_tx - n0, 12);
  endtask
  // Program flow under both concurrency settings
  task automatic t_prog;
    chk(concurrency_en, 0);
    prog_cmd_valid = 1'b1;
    traj_active = 1'b1;
    cyc(1);
    n0 = n_iss;
    cyc(3);
    chk(n_iss - n0, 0);
    concurrency_on_cmd = 1'b1;
    @(negedge ref_clk);
    concurrency_on_cmd = 1'b0;
    cyc(1);
    chk(concurrency_en, 1);
    n0 = n_iss;
    cyc(3);
    chk(n_iss - n0, 3);
    prog_cmd_long = 1'b1;
    cyc(1);
    prog_cmd_long = 1'b0;
    n0 = n_iss;
    cyc(3);
    chk(n_iss - n0, 0);
    prog_cmd_done = 1'b1;
    @(negedge ref_clk);
    prog_cmd_done = 1'b0;
    cyc(1);
    n0 = n_iss;
    cyc(3);
    chk(n_iss - n0, 3);
    prog_cmd_is_motion = 1'b1;
    n0 = n_mot;
    cyc(2);
    chk(n_mot - n0, 2);
    // Both commands at once: off must win
    concurrency_on_cmd = 1'b1;
    concurrency_off_cmd = 1'b1;
    @(negedge ref_clk);
    concurrency_on_cmd = 1'b0;
    concurrency_off_cmd = 1'b0;
    cyc(1);
    chk(concurrency_en, 0);
    traj_active = 1'b0;
    cyc(1);
    traj_active = 1'b1;
    n0 = n_iss;
    cyc(3);
    chk(n_iss - n0, 0);
    traj_active = 1'b0;
    prog_cmd_is_motion = 1'b0;
    cyc(2);
    n0 = n_iss;
    cyc(2);
    chk(n_iss - n0, 2);
    prog_cmd_valid = 1'b0;
    host_motion_cmd = 1'b1;
    n0 = n_mot;
    cyc(2);
    chk(n_mot - n0, 2);
    host_motion_cmd = 1'b0;
  endtask
  // Settle, torque limits, exit and the entry gates of the hold
  task automatic t_hold;
    cyc(1);
    chk(torque_cmd, 16'h0777);
    chk(control_output, 16'h0777);
    pos_error = 16'h0004;
    cyc(2);
    chk(open_loop, 0);
    cyc(1);
    chk(open_loop, 1);
    chk(torque_cmd, 16'h0300);
    chk(error_limit_timer, 1);
    control_output_calc = 16'h0666;
    cyc(4);
    chk(torque_cmd, 16'h0100);
    chk(error_limit_timer, 0);
    chk(control_output, 16'h0777);
    pos_error = 16'h000A;
    @(negedge ref_clk);
    chk(open_loop, 0);
    pos_error = 16'h0003;
    cyc(2);
    pos_error = 16'h0005;
    cyc(1);
    pos_error = 16'h0003;
    cyc(2);
    chk(open_loop, 0);
    cyc(1);
    chk(open_loop, 1);
    pos_error = 16'h0020;
    traj_active = 1'b1;
    cyc(1);
    pos_error = 16'h0003;
    cyc(5);
    chk(open_loop, 0);
    hold_entry_mode = 1'b1;
    cyc(4);
    chk(open_loop, 1);
    cyc(4);
    chk(torque_cmd, 16'h0100);
    pos_error = 16'h0020;
    traj_active = 1'b0;
    hold_check_torque = 1'b1;
    closed_loop_torque = 16'h0500;
    cyc(1);
    pos_error = 16'h0003;
    cyc(5);
    chk(open_loop, 0);
    closed_loop_torque = 16'h0050;
    cyc(5);
    chk(open_loop, 1);
    hold_enter_thresh = 16'h0000;
    hold_exit_thresh = 16'h0000;
    pos_error = 16'h0000;
    cyc(5);
    chk(open_loop, 0);
    // No brief entry either, even with zero error
    n0 = n_open;
    cyc(3);
    chk(n_open - n0, 0);
  endtask
  // Status words, pins and error flags each cycle
  task automatic t_stat;
    stat_word0_in = 16'h1234;
    stat_word1_in = 16'h5678;
    stat_word2_in = 16'h9ABC;
    io_in = 8'h3C;
    io_out_next = 8'hC3;
    err_user_in = 1'b1;
    cyc(2);
    chk({stat_word1, stat_word2}, 32'h56789ABC);
    chk({stat_word0, io_in_sampled, io_out}, 32'h12343CC3);
    chk(err_flag, 1);
    err_user_in = 1'b0;
    cyc(2);
    chk(err_flag, 0);
    err_fixed_in = 1'b1;
    cyc(2);
    chk(err_flag, 1);
  endtask

  // Main sequence: inputs known from time zero, reset, scenarios
  initial begin
    {rst_n, concurrency_on_cmd, concurrency_off_cmd, hold_entry_mode, hold_check_torque} = '0;
    {traj_active, stop_cond, prog_cmd_valid, prog_cmd_is_motion, prog_cmd_long} = '0;
    {prog_cmd_done, host_motion_cmd, err_user_in, err_fixed_in, send} = '0;
    {stat_word0_in, stat_word1_in, stat_word2_in, io_in, io_out_next} = '0;
    clk_en = 1'b1;
    hold_enter_thresh = 16'h0004;
    hold_exit_thresh = 16'h000A;
    hold_settle_delay = 16'h0002;
    error_limit_delay = 16'h0002;
    tq_move_limit = 16'h0300;
    tq_hold_limit = 16'h0100;
    pos_error = 16'h0020;
    closed_loop_torque = 16'h0000;
    control_output_calc = 16'h0777;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_prog();
    t_serial();
    t_hold();
    t_stat();
    final_report();
  end
  // Hang guard, well beyond the few thousand clocks the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    final_report();
  end
endmodule // scs_servo_cycle_sequencer_tb
